// file: ocd_pkg.sv
// Opcode map constants, mode and group encodings for the opcode decoder and address generator.
package ocd_pkg;

  // Addressing modes, one-hot.
  typedef enum logic [9:0] {
    bit_test_branch_mode   = 10'h001,
    single_bit_write_mode  = 10'h002,
    branch_offset_mode     = 10'h004,
    page_zero_mode         = 10'h008,
    implied_mode           = 10'h010,
    literal_operand_mode   = 10'h020,
    long_absolute_mode     = 10'h040,
    pointer_plus_word_mode = 10'h080,
    pointer_plus_byte_mode = 10'h100,
    register_pointer_mode  = 10'h200
  } ocd_mode_t;

  // Operation groups, one-hot.
  typedef enum logic [4:0] {
    grp_bit     = 5'h01,
    grp_branch  = 5'h02,
    grp_rmw     = 5'h04,
    grp_control = 5'h08,
    grp_regmem  = 5'h10
  } ocd_group_t;

  // Fetch sequencer states, one-hot.
  typedef enum logic [2:0] {
    st_opcode = 3'h1,
    st_byte1  = 3'h2,
    st_byte2  = 3'h4
  } ocd_state_t;

  // High-nibble columns of the opcode map.
  localparam logic [3:0] HI_BIT_TEST   = 4'h0;
  localparam logic [3:0] HI_BIT_WRITE  = 4'h1;
  localparam logic [3:0] HI_BRANCH     = 4'h2;
  localparam logic [3:0] HI_RMW_PAGE0  = 4'h3;
  localparam logic [3:0] HI_RMW_ACC    = 4'h4;
  localparam logic [3:0] HI_RMW_INDEX  = 4'h5;
  localparam logic [3:0] HI_RMW_PPB    = 4'h6;
  localparam logic [3:0] HI_RMW_RP     = 4'h7;
  localparam logic [3:0] HI_CTRL_LO    = 4'h8;
  localparam logic [3:0] HI_CTRL_HI    = 4'h9;
  localparam logic [3:0] HI_LITERAL    = 4'hA;
  localparam logic [3:0] HI_PAGE0      = 4'hB;
  localparam logic [3:0] HI_LONG       = 4'hC;
  localparam logic [3:0] HI_PPW        = 4'hD;
  localparam logic [3:0] HI_PPB        = 4'hE;
  localparam logic [3:0] HI_RP         = 4'hF;
  // Low nibble of the subroutine branch that lives in the literal column.
  localparam logic [3:0] LO_SUB_BRANCH = 4'hD;

  // Implemented rows per column, bit n set when low nibble n is defined.
  localparam logic [15:0] IMPL_FULL    = 16'hFFFF;
  localparam logic [15:0] IMPL_RMW     = 16'hB7D9;
  localparam logic [15:0] IMPL_RMW_ACC = 16'hB7DD;
  localparam logic [15:0] IMPL_CTRL_LO = 16'hC00B;
  localparam logic [15:0] IMPL_CTRL_HI = 16'hBF80;
  localparam logic [15:0] IMPL_LITERAL = 16'h6F7F;

  // Instruction lengths in bytes.
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Program counter value after reset.
  localparam logic [15:0] PC_RESET = 16'h0000;

endpackage

// file: ocd_map.sv
// Combinational opcode map: mode, group, length and implemented flag from one opcode byte.
`timescale 1ns/1ps
module ocd_map (
  input  wire logic [7:0]         opcode,      // Opcode byte under decode
  output ocd_pkg::ocd_mode_t      mode,        // Addressing mode
  output ocd_pkg::ocd_group_t     group,       // Operation group
  output logic      [1:0]         length,      // Instruction length in bytes
  output logic                    implemented  // Opcode position is defined
);

  logic [3:0]  hi;
  logic [3:0]  lo;
  logic [15:0] impl_mask;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    impl_mask = ocd_pkg::IMPL_FULL;
    mode      = ocd_pkg::implied_mode;
    group     = ocd_pkg::grp_control;
    length    = ocd_pkg::LEN_ONE;
    case (hi)
      ocd_pkg::HI_BIT_TEST: begin
        mode   = ocd_pkg::bit_test_branch_mode;
        group  = ocd_pkg::grp_bit;
        length = ocd_pkg::LEN_THREE;
      end
      ocd_pkg::HI_BIT_WRITE: begin
        mode   = ocd_pkg::single_bit_write_mode;
        group  = ocd_pkg::grp_bit;
        length = ocd_pkg::LEN_TWO;
      end
      ocd_pkg::HI_BRANCH: begin
        mode   = ocd_pkg::branch_offset_mode;
        group  = ocd_pkg::grp_branch;
        length = ocd_pkg::LEN_TWO;
      end
      ocd_pkg::HI_RMW_PAGE0: begin
        mode      = ocd_pkg::page_zero_mode;
        group     = ocd_pkg::grp_rmw;
        length    = ocd_pkg::LEN_TWO;
        impl_mask = ocd_pkg::IMPL_RMW;
      end
      ocd_pkg::HI_RMW_ACC: begin
        group     = ocd_pkg::grp_rmw;
        impl_mask = ocd_pkg::IMPL_RMW_ACC;
      end
      ocd_pkg::HI_RMW_INDEX: begin
        group     = ocd_pkg::grp_rmw;
        impl_mask = ocd_pkg::IMPL_RMW;
      end
      ocd_pkg::HI_RMW_PPB: begin
        mode      = ocd_pkg::pointer_plus_byte_mode;
        group     = ocd_pkg::grp_rmw;
        length    = ocd_pkg::LEN_TWO;
        impl_mask = ocd_pkg::IMPL_RMW;
      end
      ocd_pkg::HI_RMW_RP: begin
        mode      = ocd_pkg::register_pointer_mode;
        group     = ocd_pkg::grp_rmw;
        impl_mask = ocd_pkg::IMPL_RMW;
      end
      ocd_pkg::HI_CTRL_LO: impl_mask = ocd_pkg::IMPL_CTRL_LO;
      ocd_pkg::HI_CTRL_HI: impl_mask = ocd_pkg::IMPL_CTRL_HI;
      ocd_pkg::HI_LITERAL: begin
        impl_mask = ocd_pkg::IMPL_LITERAL;
        length    = ocd_pkg::LEN_TWO;
        if (lo == ocd_pkg::LO_SUB_BRANCH) begin
          mode = ocd_pkg::branch_offset_mode;
        end else begin
          mode  = ocd_pkg::literal_operand_mode;
          group = ocd_pkg::grp_regmem;
        end
      end
      ocd_pkg::HI_PAGE0: begin
        mode   = ocd_pkg::page_zero_mode;
        group  = ocd_pkg::grp_regmem;
        length = ocd_pkg::LEN_TWO;
      end
      ocd_pkg::HI_LONG: begin
        mode   = ocd_pkg::long_absolute_mode;
        group  = ocd_pkg::grp_regmem;
        length = ocd_pkg::LEN_THREE;
      end
      ocd_pkg::HI_PPW: begin
        mode   = ocd_pkg::pointer_plus_word_mode;
        group  = ocd_pkg::grp_regmem;
        length = ocd_pkg::LEN_THREE;
      end
      ocd_pkg::HI_PPB: begin
        mode   = ocd_pkg::pointer_plus_byte_mode;
        group  = ocd_pkg::grp_regmem;
        length = ocd_pkg::LEN_TWO;
      end
      default: begin
        mode  = ocd_pkg::register_pointer_mode;
        group = ocd_pkg::grp_regmem;
      end
    endcase
    if (!impl_mask[lo]) begin
      mode   = ocd_pkg::implied_mode;
      group  = ocd_pkg::grp_control;
      length = ocd_pkg::LEN_ONE;
    end
  end

  assign implemented = impl_mask[lo];

endmodule

// file: ocd_decode.sv
// Opcode decoder and operand location generator with program counter stepping.
`timescale 1ns/1ps
// Notes on behaviour
// - Long absolute address is the next two bytes, high first; PC steps by three.
// - Long absolute mode reaches the whole 64K map, not only page zero.
// - Register pointer address is the index register with upper byte zero.
// - Register pointer instructions are one byte long; PC steps by one.
// - High nibble 0 is bit test and branch, 1 is bit set or clear.
// - High nibbles A to F select literal, page zero, long, word, byte, pointer.
// - High nibbles 3 to 7 are the read-modify-write forms; 2 holds branches.
// - Pointer plus byte adds index and byte; carry becomes the upper byte.
// - Branch target is next instruction plus signed offset, only when taken.
module ocd_decode (
  input  wire logic        clk,            // Core clock
  input  wire logic        reset,          // Asynchronous reset, active high
  input  wire logic        byte_valid,     // Fetch unit presents a byte
  input  wire logic [7:0]  byte_data,      // Opcode or operand byte
  input  wire logic [7:0]  index_reg,      // Current index register
  input  wire logic        branch_cond,    // Branch condition holds, sampled on last byte
  output logic      [15:0] fetch_addr_q,   // Address of the next byte to fetch
  output logic      [15:0] ea_q,           // Operand location
  output logic             ea_valid_q,     // Operand location valid, one cycle
  output logic             done_q,         // Instruction decoded, one cycle
  output logic             unimpl_q,       // Blank opcode seen, one cycle
  output ocd_pkg::ocd_mode_t  mode_q,      // Addressing mode of last instruction
  output ocd_pkg::ocd_group_t group_q,     // Operation group of last instruction
  output logic      [3:0]  op_q,           // Low nibble, the operation select
  output logic      [2:0]  bit_num_q,      // Bit number for bit groups
  output logic             bit_sense_q,    // 1 for set or branch-if-set
  output logic             branch_taken_q  // Branch redirected the PC
);

  ocd_pkg::ocd_state_t state_q;
  logic [7:0]  opc_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic [15:0] inst_pc_q;

  logic [7:0]  cur_opc;
  logic [7:0]  cur_b1;
  logic [15:0] start_pc;
  ocd_pkg::ocd_mode_t  dec_mode;
  ocd_pkg::ocd_group_t dec_group;
  logic [1:0]  dec_len;
  logic        dec_impl;
  logic        finish;
  logic        taken;
  logic [15:0] ea_d;
  logic [15:0] next_pc_d;
  logic [15:0] rel_target;
  logic [15:0] btb_target;
  logic [8:0]  ppb_sum;

  // Operands seen in the finishing cycle come straight from the bus, earlier ones from the capture flops.
  assign cur_opc  = (state_q == ocd_pkg::st_opcode) ? byte_data : opc_q;
  assign cur_b1   = (state_q == ocd_pkg::st_byte1) ? byte_data : b1_q;
  assign start_pc = (state_q == ocd_pkg::st_opcode) ? fetch_addr_q : inst_pc_q;

  ocd_map u_map (
    .opcode      (cur_opc),
    .mode        (dec_mode),
    .group       (dec_group),
    .length      (dec_len),
    .implemented (dec_impl)
  );

  assign finish = byte_valid &&
                  (((state_q == ocd_pkg::st_opcode) && (dec_len == ocd_pkg::LEN_ONE)) ||
                   ((state_q == ocd_pkg::st_byte1) && (dec_len == ocd_pkg::LEN_TWO)) ||
                   (state_q == ocd_pkg::st_byte2));

  assign rel_target = start_pc + {14'h0000, ocd_pkg::LEN_TWO} + {{8{cur_b1[7]}}, cur_b1};
  assign btb_target = start_pc + {14'h0000, ocd_pkg::LEN_THREE} + {{8{byte_data[7]}}, byte_data};
  assign ppb_sum    = {1'b0, index_reg} + {1'b0, cur_b1};

  assign taken = branch_cond && dec_impl &&
                 ((dec_mode == ocd_pkg::branch_offset_mode) || (dec_mode == ocd_pkg::bit_test_branch_mode));

  always_comb begin
    ea_d = 16'h0000;
    case (dec_mode)
      ocd_pkg::bit_test_branch_mode,
      ocd_pkg::single_bit_write_mode,
      ocd_pkg::page_zero_mode:         ea_d = {8'h00, cur_b1};
      // untaken branch points at next instruction
      ocd_pkg::branch_offset_mode:     ea_d = taken ? rel_target : start_pc + {14'h0000, ocd_pkg::LEN_TWO};
      ocd_pkg::literal_operand_mode:   ea_d = start_pc + 16'h0001;
      ocd_pkg::long_absolute_mode:     ea_d = {cur_b1, byte_data};
      ocd_pkg::pointer_plus_word_mode: ea_d = {cur_b1, byte_data} + {8'h00, index_reg};
      ocd_pkg::pointer_plus_byte_mode: ea_d = {7'h00, ppb_sum};
      ocd_pkg::register_pointer_mode:  ea_d = {8'h00, index_reg};
      default:                         ea_d = 16'h0000;
    endcase
  end

  always_comb begin
    next_pc_d = start_pc + {14'h0000, dec_len};
    if (taken && (dec_mode == ocd_pkg::branch_offset_mode)) begin
      next_pc_d = rel_target;
    end else if (taken) begin
      next_pc_d = btb_target;
    end
  end

  // Fetch sequencer: waits for the operand bytes that the opcode calls for.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ocd_pkg::st_opcode;
    end else if (byte_valid) begin
      case (state_q)
        ocd_pkg::st_opcode: state_q <= finish ? ocd_pkg::st_opcode : ocd_pkg::st_byte1;
        ocd_pkg::st_byte1:  state_q <= finish ? ocd_pkg::st_opcode : ocd_pkg::st_byte2;
        ocd_pkg::st_byte2:  state_q <= ocd_pkg::st_opcode;
        default:            state_q <= ocd_pkg::st_opcode;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opc_q     <= 8'h00;
      b1_q      <= 8'h00;
      b2_q      <= 8'h00;
      inst_pc_q <= ocd_pkg::PC_RESET;
    end else if (byte_valid) begin
      if (state_q == ocd_pkg::st_opcode) begin
        opc_q     <= byte_data;
        inst_pc_q <= fetch_addr_q;
      end
      if (state_q == ocd_pkg::st_byte1) begin
        b1_q <= byte_data;
      end
      if (state_q == ocd_pkg::st_byte2) begin
        b2_q <= byte_data;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fetch_addr_q <= ocd_pkg::PC_RESET;
    end else if (finish) begin
      fetch_addr_q <= next_pc_d;
    end else if (byte_valid) begin
      fetch_addr_q <= fetch_addr_q + 16'h0001;
    end
  end

  // unimplemented opcodes get no operand location
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_q         <= 1'b0;
      ea_valid_q     <= 1'b0;
      unimpl_q       <= 1'b0;
      branch_taken_q <= 1'b0;
    end else begin
      done_q         <= finish;
      ea_valid_q     <= finish && dec_impl && (dec_mode != ocd_pkg::implied_mode);
      unimpl_q       <= finish && !dec_impl;
      branch_taken_q <= finish && taken;
    end
  end

  // decoded fields held until the next instruction completes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ea_q        <= 16'h0000;
      mode_q      <= ocd_pkg::implied_mode;
      group_q     <= ocd_pkg::grp_control;
      op_q        <= 4'h0;
      bit_num_q   <= 3'h0;
      bit_sense_q <= 1'b0;
    end else if (finish) begin
      ea_q        <= ea_d;
      mode_q      <= dec_mode;
      group_q     <= dec_group;
      op_q        <= cur_opc[3:0];
      bit_num_q   <= cur_opc[3:1];
      bit_sense_q <= ~cur_opc[0];
    end
  end

  sequence seq_rp_opcode;
    (state_q == ocd_pkg::st_opcode) && byte_valid && dec_impl &&
    (dec_mode == ocd_pkg::register_pointer_mode);
  endsequence

  sequence seq_one_step;
    done_q && (fetch_addr_q == $past(fetch_addr_q) + 16'h0001);
  endsequence

  chk_long_abs_addr: assert property (@(posedge clk) disable iff (reset)
    (done_q && mode_q == ocd_pkg::long_absolute_mode) |->
    (ea_q == {b1_q, b2_q}) && (fetch_addr_q == inst_pc_q + 16'h0003))
    else $error("long absolute address or PC step wrong");

  chk_long_abs_reach: assert property (@(posedge clk) disable iff (reset)
    (done_q && mode_q == ocd_pkg::long_absolute_mode) |-> (ea_q[15:8] == b1_q))
    else $error("long absolute upper byte lost");

  chk_ptr_upper_zero: assert property (@(posedge clk) disable iff (reset)
    (ea_valid_q && mode_q == ocd_pkg::register_pointer_mode) |->
    (ea_q == {8'h00, $past(index_reg)}))
    else $error("register pointer address wrong");

  chk_ptr_one_byte: assert property (@(posedge clk) disable iff (reset)
    seq_rp_opcode |=> seq_one_step)
    else $error("register pointer instruction not one byte");

  chk_bit_group_map: assert property (@(posedge clk) disable iff (reset)
    (done_q && opc_q[7:4] == ocd_pkg::HI_BIT_TEST) |->
    (mode_q == ocd_pkg::bit_test_branch_mode) && (bit_num_q == opc_q[3:1]) && (bit_sense_q == !opc_q[0]))
    else $error("bit test group decoded wrong");

  chk_regmem_map: assert property (@(posedge clk) disable iff (reset)
    (done_q && opc_q[7:4] == ocd_pkg::HI_PPW) |->
    (mode_q == ocd_pkg::pointer_plus_word_mode) && (group_q == ocd_pkg::grp_regmem))
    else $error("pointer plus word column decoded wrong");

  chk_rmw_map: assert property (@(posedge clk) disable iff (reset)
    (done_q && !unimpl_q && opc_q[7:4] == ocd_pkg::HI_RMW_RP) |->
    (mode_q == ocd_pkg::register_pointer_mode) && (group_q == ocd_pkg::grp_rmw))
    else $error("read-modify-write pointer column decoded wrong");

  chk_ppb_carry: assert property (@(posedge clk) disable iff (reset)
    (ea_valid_q && mode_q == ocd_pkg::pointer_plus_byte_mode) |->
    (ea_q == {7'h00, {1'b0, $past(index_reg)} + {1'b0, b1_q}}))
    else $error("pointer plus byte address wrong");

  chk_branch_target: assert property (@(posedge clk) disable iff (reset)
    (done_q && mode_q == ocd_pkg::branch_offset_mode) |->
    (fetch_addr_q == (branch_taken_q ? inst_pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q}
                                     : inst_pc_q + 16'h0002)) && (ea_q == fetch_addr_q))
    else $error("branch target wrong");

  chk_unimpl_quiet: assert property (@(posedge clk) disable iff (reset)
    unimpl_q |-> done_q && !ea_valid_q && !branch_taken_q && (mode_q == ocd_pkg::implied_mode))
    else $error("unimplemented opcode started an operation");

endmodule

// file: ocd_fetch_model.sv
// Fetch unit model: presents program bytes from a byte array at the decoder's fetch address.
`timescale 1ns/1ps
module ocd_fetch_model (
  input  wire logic        clk,         // Core clock
  input  wire logic        reset,       // Asynchronous reset, active high
  input  wire logic        run,         // Bench asks for bytes to flow
  input  wire logic        stall,       // Bench holds the stream back for a cycle
  input  wire logic [15:0] fetch_addr,  // Address of the next byte wanted
  output logic             byte_valid,  // A byte is presented this cycle
  output logic      [7:0]  byte_data    // Presented byte
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  assign byte_valid = run & ~stall;
  // Outside a transfer the data lines show the inverse of the last byte, so a decoder
  // that samples them when no byte is offered picks up a value that is plainly wrong.
  assign byte_data = byte_valid ? mem[fetch_addr] : ~last_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_q <= 8'h00;
    end else if (byte_valid) begin
      last_q <= byte_data;
    end
  end
endmodule

// file: tb.sv
// Self-checking testbench for the opcode decoder and operand location generator.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s expected %0h seen %0h", nm, (e), (g)); end end
module tb;
  logic                clk;
  logic                reset;
  logic                run;
  logic                stall;
  logic [7:0]          index_reg;
  logic                branch_cond;
  logic                byte_valid;
  logic [7:0]          byte_data;
  logic [15:0]         fetch_addr_q;
  logic [15:0]         ea_q;
  logic                ea_valid_q;
  logic                done_q;
  logic                unimpl_q;
  ocd_pkg::ocd_mode_t  mode_q;
  ocd_pkg::ocd_group_t group_q;
  logic [3:0]          op_q;
  logic [2:0]          bit_num_q;
  logic                bit_sense_q;
  logic                branch_taken_q;
  int                  fails;
  int                  check_count;
  logic [15:0]         pc;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  ocd_decode i_ocd_decode (.clk(clk), .reset(reset), .byte_valid(byte_valid), .byte_data(byte_data),
    .index_reg(index_reg), .branch_cond(branch_cond), .fetch_addr_q(fetch_addr_q), .ea_q(ea_q),
    .ea_valid_q(ea_valid_q), .done_q(done_q), .unimpl_q(unimpl_q), .mode_q(mode_q), .group_q(group_q),
    .op_q(op_q), .bit_num_q(bit_num_q), .bit_sense_q(bit_sense_q), .branch_taken_q(branch_taken_q));

  ocd_fetch_model i_ocd_fetch_model (.clk(clk), .reset(reset), .run(run), .stall(stall),
    .fetch_addr(fetch_addr_q), .byte_valid(byte_valid), .byte_data(byte_data));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic int len_of(input logic [3:0] hi);
    case (hi)
      4'h0, 4'hC, 4'hD: len_of = 3;
      4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hF: len_of = 1;
      default: len_of = 2;
    endcase
  endfunction

  // Streams one instruction at the current pc; gap inserts one idle cycle after the opcode.
  task automatic exec(input logic [7:0] b0, b1, b2, input int len, input logic [7:0] x,
                      input logic cond, input logic gap);
    int sent;
    int n;
    @(negedge clk);
    i_ocd_fetch_model.mem[pc] = b0;
    i_ocd_fetch_model.mem[pc + 16'h0001] = b1;
    i_ocd_fetch_model.mem[pc + 16'h0002] = b2;
    index_reg = x;
    branch_cond = cond;
    run = 1'b1;
    sent = 0;
    n = 0;
    while (sent < len && n < 20) begin
      @(posedge clk);
      if (byte_valid) sent++;
      n++;
      @(negedge clk);
      stall = gap && (n == 1);
    end
    run = 1'b0;
    stall = 1'b0;
    if (sent < len) begin
      fails++;
      tally_and_finish;
    end
  endtask

  // The answer pulse lands one cycle after the last byte, which is this falling edge.
  task automatic chk(input logic [15:0] ea_e, pc_e, input ocd_pkg::ocd_mode_t m, input logic ev);
    `CHK("done", 1'b1, done_q)
    `CHK("ea_valid", ev, ea_valid_q)
    if (ev) `CHK("ea", ea_e, ea_q)
    `CHK("pc", pc_e, fetch_addr_q)
    `CHK("mode", m, mode_q)
    pc = pc_e;
  endtask

  task automatic s_long_abs;
    exec(8'hC6, 8'h12, 8'h34, 3, 8'h00, 1'b0, 1'b0);
    chk(16'h1234, pc + 16'h0003, ocd_pkg::long_absolute_mode, 1'b1);
    exec(8'hC6, 8'hFF, 8'hFE, 3, 8'h55, 1'b0, 1'b1);
    chk(16'hFFFE, pc + 16'h0003, ocd_pkg::long_absolute_mode, 1'b1);
  endtask

  task automatic s_reg_ptr;
    exec(8'hF6, 8'h00, 8'h00, 1, 8'h80, 1'b0, 1'b0);
    chk(16'h0080, pc + 16'h0001, ocd_pkg::register_pointer_mode, 1'b1);
    exec(8'hF6, 8'hAA, 8'hAA, 1, 8'hFF, 1'b0, 1'b0);
    chk(16'h00FF, pc + 16'h0001, ocd_pkg::register_pointer_mode, 1'b1);
  endtask

  task automatic s_ptr_byte;
    exec(8'hE6, 8'hFF, 8'h00, 2, 8'hFF, 1'b0, 1'b1);
    chk(16'h01FE, pc + 16'h0002, ocd_pkg::pointer_plus_byte_mode, 1'b1);
    exec(8'hE6, 8'h02, 8'h00, 2, 8'h01, 1'b0, 1'b0);
    chk(16'h0003, pc + 16'h0002, ocd_pkg::pointer_plus_byte_mode, 1'b1);
  endtask

  task automatic s_branch;
    exec(8'h26, 8'hFE, 8'h00, 2, 8'h00, 1'b1, 1'b0);
    chk(pc, pc, ocd_pkg::branch_offset_mode, 1'b1);
    `CHK("taken", 1'b1, branch_taken_q)
    `CHK("group", ocd_pkg::grp_branch, group_q)
    exec(8'h26, 8'h7F, 8'h00, 2, 8'h00, 1'b1, 1'b0);
    chk(pc + 16'h0081, pc + 16'h0081, ocd_pkg::branch_offset_mode, 1'b1);
    exec(8'h26, 8'h10, 8'h00, 2, 8'h00, 1'b0, 1'b0);
    chk(pc + 16'h0002, pc + 16'h0002, ocd_pkg::branch_offset_mode, 1'b1);
    `CHK("not taken", 1'b0, branch_taken_q)
    exec(8'hAD, 8'h04, 8'h00, 2, 8'h00, 1'b1, 1'b0);
    chk(pc + 16'h0006, pc + 16'h0006, ocd_pkg::branch_offset_mode, 1'b1);
    `CHK("sub group", ocd_pkg::grp_control, group_q)
  endtask

  task automatic s_bit_groups;
    exec(8'h07, 8'h40, 8'h10, 3, 8'h00, 1'b1, 1'b0);
    chk(16'h0040, pc + 16'h0013, ocd_pkg::bit_test_branch_mode, 1'b1);
    `CHK("bit num", 3'h3, bit_num_q)
    `CHK("bit sense", 1'b0, bit_sense_q)
    exec(8'h1C, 8'h33, 8'h00, 2, 8'h00, 1'b0, 1'b0);
    chk(16'h0033, pc + 16'h0002, ocd_pkg::single_bit_write_mode, 1'b1);
    `CHK("bit num", 3'h6, bit_num_q)
    `CHK("bit sense", 1'b1, bit_sense_q)
  endtask

  task automatic s_mode_table;
    logic [3:0] his [11];
    ocd_pkg::ocd_mode_t ms [11];
    logic [15:0] eas [11];
    his = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    ms = '{ocd_pkg::literal_operand_mode, ocd_pkg::page_zero_mode, ocd_pkg::long_absolute_mode,
           ocd_pkg::pointer_plus_word_mode, ocd_pkg::pointer_plus_byte_mode, ocd_pkg::register_pointer_mode,
           ocd_pkg::page_zero_mode, ocd_pkg::implied_mode, ocd_pkg::implied_mode,
           ocd_pkg::pointer_plus_byte_mode, ocd_pkg::register_pointer_mode};
    eas = '{16'h0000, 16'h0001, 16'h0102, 16'h0112, 16'h0011, 16'h0010,
            16'h0001, 16'h0000, 16'h0000, 16'h0011, 16'h0010};
    for (int i = 0; i < 11; i++) begin
      exec({his[i], 4'h3}, 8'h01, 8'h02, len_of(his[i]), 8'h10, 1'b0, 1'b0);
      `CHK("mode", ms[i], mode_q)
      `CHK("group", (i < 6) ? ocd_pkg::grp_regmem : ocd_pkg::grp_rmw, group_q)
      `CHK("op", 4'h3, op_q)
      `CHK("ea_valid", (i != 7) && (i != 8), ea_valid_q)
      if ((i != 7) && (i != 8)) `CHK("ea", (i == 0) ? pc + 16'h0001 : eas[i], ea_q)
      `CHK("pc", pc + 16'(len_of(his[i])), fetch_addr_q)
      pc = pc + 16'(len_of(his[i]));
    end
  endtask

  task automatic s_unimpl;
    logic [7:0] ops [4];
    ops = '{8'h31, 8'h82, 8'hA7, 8'h9E};
    for (int i = 0; i < 4; i++) begin
      exec(ops[i], 8'h00, 8'h00, 1, 8'h00, 1'b0, 1'b0);
      `CHK("unimpl", 1'b1, unimpl_q)
      chk(16'h0000, pc + 16'h0001, ocd_pkg::implied_mode, 1'b0);
    end
  endtask

  // A second reset in mid-run must return the counter and fields to their idle values.
  task automatic s_reset;
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("reset pc", ocd_pkg::PC_RESET, fetch_addr_q)
    `CHK("reset mode", ocd_pkg::implied_mode, mode_q)
    `CHK("reset done", 1'b0, done_q)
    reset = 1'b0;
    pc = ocd_pkg::PC_RESET;
  endtask

  initial begin
    reset = 1'b1;
    run = 1'b0;
    stall = 1'b0;
    index_reg = 8'h00;
    branch_cond = 1'b0;
    fails = 0;
    check_count = 0;
    pc = 16'h0000;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    s_long_abs;
    s_reg_ptr;
    s_ptr_byte;
    s_branch;
    s_bit_groups;
    s_reset;
    s_mode_table;
    s_unimpl;
    tally_and_finish;
  end
endmodule
